//--- design/lmr_consts.svh
`ifndef LMR_CONSTS_SVH
`define LMR_CONSTS_SVH

// Clock period in picoseconds (250 MHz core clock)
`define LMR_CLK_PS 4000
// Array shape
`define LMR_ADDR_W 13
`define LMR_DATA_W 8
`define LMR_DEPTH 8192
// Fast grade timing, ns
`define LMR_F_CYCLE_NS 375
`define LMR_F_LOW_NS 250
`define LMR_F_ACCESS_NS 250
`define LMR_F_HOLD_NS 60
`define LMR_F_PRECH_NS 125
`define LMR_F_OFF_NS 60
// Slow grade timing, ns
`define LMR_S_CYCLE_NS 450
`define LMR_S_LOW_NS 300
`define LMR_S_ACCESS_NS 300
`define LMR_S_HOLD_NS 75
`define LMR_S_PRECH_NS 150
`define LMR_S_OFF_NS 75
// Address setup before enable falls, ns
`define LMR_SETUP_NS 0
// Least time rounds up to whole cycles, never below one
`define LMR_CYC_MIN(ns) (((ns) * 1000 + `LMR_CLK_PS - 1) / `LMR_CLK_PS)
`define LMR_CYC_UP(ns) ((`LMR_CYC_MIN(ns) < 1) ? 1 : `LMR_CYC_MIN(ns))
// Width of the phase counter
`define LMR_CNT_W 8
// Synchroniser depth for pin inputs
`define LMR_SYNC_N 3

`endif

//--- design/lmr_pkg.sv
package lmr_pkg;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_SETUP = 6'h02,
        ST_HOLD  = 6'h04,
        ST_WAIT  = 6'h08,
        ST_SAMP  = 6'h10,
        ST_PRECH = 6'h20
    } lmr_state_t;

    typedef logic [7:0] lmr_cnt_t;

endpackage

//--- design/lmr_sync.sv
`timescale 1ns/10ps
`include "lmr_consts.svh"

// Three-stage synchroniser per bit; a change counts once stages two and three agree
module lmr_sync #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // Shift chain; first stage is read only by the second
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Per-bit agreement filter
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    level_out[i] <= 1'b0;
                end else if (s2_reg[i] == s3_reg[i]) begin
                    level_out[i] <= s3_reg[i];
                end
            end
        end
    endgenerate

endmodule

//--- design/lmr_host.sv
`timescale 1ns/10ps
`include "lmr_consts.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Falling edges of the enable are at least 375 ns fast or 450 ns slow apart.
// - The enable stays low at least 250 ns fast or 300 ns slow in each cycle.
// - The address stays stable at least 60 ns fast or 75 ns slow after the enable falls.
// - The address is valid no later than the falling edge of the enable.
// - Between cycles the enable stays high at least 125 ns fast or 150 ns slow.
module lmr_host (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic slow_grade,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [12:0] req_index,
    output logic rsp_valid,
    output logic [7:0] rsp_byte,
    output logic rom_enable_n,
    output logic [12:0] word_index,
    input wire logic [7:0] byte_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts derived from the timing figures
    // Each figure rounds up to whole cycles, so no least time is shortened

    localparam lmr_pkg::lmr_cnt_t F_LOW = 8'(`LMR_CYC_UP(`LMR_F_LOW_NS));
    localparam lmr_pkg::lmr_cnt_t S_LOW = 8'(`LMR_CYC_UP(`LMR_S_LOW_NS));
    localparam lmr_pkg::lmr_cnt_t F_ACC = 8'(`LMR_CYC_UP(`LMR_F_ACCESS_NS));
    localparam lmr_pkg::lmr_cnt_t S_ACC = 8'(`LMR_CYC_UP(`LMR_S_ACCESS_NS));
    localparam lmr_pkg::lmr_cnt_t F_HOLD = 8'(`LMR_CYC_UP(`LMR_F_HOLD_NS));
    localparam lmr_pkg::lmr_cnt_t S_HOLD = 8'(`LMR_CYC_UP(`LMR_S_HOLD_NS));
    localparam lmr_pkg::lmr_cnt_t F_PRE = 8'(`LMR_CYC_UP(`LMR_F_PRECH_NS));
    localparam lmr_pkg::lmr_cnt_t S_PRE = 8'(`LMR_CYC_UP(`LMR_S_PRECH_NS));
    localparam lmr_pkg::lmr_cnt_t F_OFF = 8'(`LMR_CYC_UP(`LMR_F_OFF_NS));
    localparam lmr_pkg::lmr_cnt_t S_OFF = 8'(`LMR_CYC_UP(`LMR_S_OFF_NS));
    localparam lmr_pkg::lmr_cnt_t F_CYC = 8'(`LMR_CYC_UP(`LMR_F_CYCLE_NS));
    localparam lmr_pkg::lmr_cnt_t S_CYC = 8'(`LMR_CYC_UP(`LMR_S_CYCLE_NS));
    // Pin synchroniser adds latency before a sample reflects the pins
    localparam lmr_pkg::lmr_cnt_t SYNC_LAT = 8'(`LMR_SYNC_N + 1);

    // Selects the fast or slow figure
    function automatic lmr_pkg::lmr_cnt_t pick(input logic slow,
                                               input lmr_pkg::lmr_cnt_t f,
                                               input lmr_pkg::lmr_cnt_t s);
        pick = slow ? s : f;
    endfunction

    // True when the sequencer sits in the given state
    function automatic logic is_state(input lmr_pkg::lmr_state_t cur,
                                      input lmr_pkg::lmr_state_t want);
        is_state = (cur == want);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    lmr_pkg::lmr_state_t state_reg;
    lmr_pkg::lmr_cnt_t cnt_reg;
    lmr_pkg::lmr_cnt_t cyc_reg;
    logic grade_reg;
    logic [12:0] index_reg;
    logic [7:0] byte_reg;
    logic rsp_valid_reg;
    logic en_n_reg;
    logic [7:0] byte_sync;
    // Least low time and least high time for the latched grade
    lmr_pkg::lmr_cnt_t low_need;
    lmr_pkg::lmr_cnt_t pre_need;
    // Decoded strobes: request taken, enable about to fall, byte about to be sampled
    logic take_w;
    logic fall_w;
    logic samp_w;

    // Data pins come from outside this clock's domain
    // Address and enable are outputs of flops here, so they need no sync
    lmr_sync #(
        .W(`LMR_DATA_W)
    ) u_sync (
        .core_clk(core_clk),
        .resetn(resetn),
        .pin_in(byte_out),
        .level_out(byte_sync)
    );

    // Enable-low time must cover access plus pin latency and the least low time
    // A byte can reach the flops up to a cycle after its access time ends
    always_comb begin
        low_need = pick(grade_reg, F_ACC, S_ACC) + SYNC_LAT;
        if (low_need < pick(grade_reg, F_LOW, S_LOW)) begin
            low_need = pick(grade_reg, F_LOW, S_LOW);
        end
        // Precharge also waits for the ROM to float its outputs
        pre_need = pick(grade_reg, F_PRE, S_PRE);
        if (pre_need < pick(grade_reg, F_OFF, S_OFF)) begin
            pre_need = pick(grade_reg, F_OFF, S_OFF);
        end
    end

    // Strobes decoded once for the sequencer and the pin processes
    assign take_w = req_ready && req_valid;
    assign fall_w = is_state(state_reg, lmr_pkg::ST_SETUP);
    assign samp_w = is_state(state_reg, lmr_pkg::ST_SAMP);

    // Handshake and pin outputs
    assign req_ready = is_state(state_reg, lmr_pkg::ST_IDLE);
    assign rom_enable_n = en_n_reg;
    assign word_index = index_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_byte = byte_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    // Phase order only; the timing counts live in the counters below
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= lmr_pkg::ST_IDLE;
        end else begin
            unique case (state_reg)
                lmr_pkg::ST_IDLE: begin
                    // Wait for a request; ready is high only here
                    if (take_w) begin
                        state_reg <= lmr_pkg::ST_SETUP;
                    end
                end
                lmr_pkg::ST_SETUP: begin
                    // Address driven one cycle before the enable falls
                    state_reg <= lmr_pkg::ST_HOLD;
                end
                lmr_pkg::ST_HOLD: begin
                    // Enable low; covers access time plus the pin synchroniser
                    if (cnt_reg >= low_need) begin
                        state_reg <= lmr_pkg::ST_SAMP;
                    end
                end
                lmr_pkg::ST_SAMP: begin
                    // Byte taken and enable raised on this edge
                    state_reg <= lmr_pkg::ST_PRECH;
                end
                lmr_pkg::ST_PRECH: begin
                    // Enable high until both precharge and cycle spacing are met
                    if (cnt_reg >= pre_need
                        && cyc_reg >= pick(grade_reg, F_CYC, S_CYC)) begin
                        state_reg <= lmr_pkg::ST_IDLE;
                    end
                end
                lmr_pkg::ST_WAIT: begin
                    // Spare code; never entered, returns to idle
                    state_reg <= lmr_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Phase counter; restarts as the low phase and the precharge begin
    // Holding it outside the timed phases keeps it from running on idle
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= '0;
        end else if (fall_w || samp_w) begin
            cnt_reg <= 8'h01;
        end else if (state_reg == lmr_pkg::ST_HOLD || state_reg == lmr_pkg::ST_PRECH) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // Counts cycles since the last enable fall
    // Saturates so that a long idle spell never wraps below the spacing figure
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cyc_reg <= '0;
        end else if (fall_w) begin
            cyc_reg <= 8'h00;
        end else if (cyc_reg != 8'hFF) begin
            cyc_reg <= cyc_reg + 8'h01;
        end
    end

    // Request capture; address held through the whole low phase
    // Grade latched with the address, so slow_grade may move while busy
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            index_reg <= '0;
            grade_reg <= 1'b0;
        end else if (take_w) begin
            index_reg <= req_index;
            grade_reg <= slow_grade;
        end
    end

    // Enable pin; low from the cycle after setup until sampling
    // Driven from a flop so the pin cannot glitch between phases
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            en_n_reg <= 1'b1;
        end else if (fall_w) begin
            en_n_reg <= 1'b0;
        end else if (samp_w) begin
            en_n_reg <= 1'b1;
        end
    end

    // Data sample taken at the end of the low phase
    // Taken late enough that all synchroniser stages hold the access data
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            byte_reg <= '0;
            rsp_valid_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= samp_w;
            if (samp_w) begin
                byte_reg <= byte_sync;
            end
        end
    end

endmodule

//--- verification/lmr_host_props.sv
`timescale 1ns/10ps
// Watches enable, address and response timing at the host ports
module lmr_host_props (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic slow_grade,
    input wire logic req_valid,
    input wire logic req_ready,
    input wire logic [12:0] req_index,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_byte,
    input wire logic rom_enable_n,
    input wire logic [12:0] word_index,
    input wire logic [7:0] byte_out
);
    logic [7:0] low_reg, hi_reg, gap_reg;
    logic slow_reg, both_reg;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    // Saturating counts of low time, high time and fall-to-fall spacing
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            low_reg <= 8'h00;
            hi_reg <= 8'hFF;
            gap_reg <= 8'hFF;
            slow_reg <= 1'b0;
            both_reg <= 1'b0;
        end else begin
            low_reg <= rom_enable_n ? 8'h00 : (low_reg == 8'hFF ? low_reg : low_reg + 8'h01);
            hi_reg <= !rom_enable_n ? 8'h00 : (hi_reg == 8'hFF ? hi_reg : hi_reg + 8'h01);
            gap_reg <= $fell(rom_enable_n) ? 8'h01 : (gap_reg == 8'hFF ? gap_reg : gap_reg + 8'h01);
            if (req_valid && req_ready) begin
                slow_reg <= slow_grade;
                both_reg <= slow_grade && slow_reg;
            end
        end
    end
    ////////////////////////////////////////
    sequence s_take; req_valid && req_ready; endsequence
    sequence s_fall; $fell(rom_enable_n); endsequence
    property p_fall_after_take; s_take |-> ##[1:3] s_fall; endproperty
    property p_index_load; s_take |=> word_index == $past(req_index); endproperty
    property p_setup; s_fall |-> $stable(word_index); endproperty
    property p_hold; (!rom_enable_n && low_reg < 8'h13) |-> $stable(word_index); endproperty
    property p_low; $rose(rom_enable_n) |-> low_reg >= (slow_reg ? 8'h4B : 8'h3F); endproperty
    property p_prech; s_fall |-> hi_reg >= (both_reg ? 8'h26 : 8'h20); endproperty
    property p_cycle; s_fall |-> gap_reg >= (both_reg ? 8'h71 : 8'h5E); endproperty
    property p_rsp; s_fall |-> ##[63:95] rsp_valid; endproperty
    property p_busy; !rom_enable_n |-> !req_ready; endproperty
    a_fall_after_take: assert property (p_fall_after_take) else $error("no enable fall");
    a_index_load: assert property (p_index_load) else $error("index not loaded");
    a_setup: assert property (p_setup) else $error("address moved at fall");
    a_hold: assert property (p_hold) else $error("address moved in hold");
    a_low: assert property (p_low) else $error("enable low too short");
    a_prech: assert property (p_prech) else $error("precharge too short");
    a_cycle: assert property (p_cycle) else $error("cycle too short");
    a_rsp: assert property (p_rsp) else $error("no response in time");
    a_busy: assert property (p_busy) else $error("ready while busy");
endmodule
bind lmr_host lmr_host_props chk_u (.core_clk, .resetn, .slow_grade, .req_valid, .req_ready,
    .req_index, .rsp_valid, .rsp_byte, .rom_enable_n, .word_index, .byte_out);

//--- verification/lmr_rom_model.sv
`timescale 1ns/10ps
// Behavioural read-only array with enable-latched address
module lmr_rom_model #(
    parameter int F_ACC_NS = 250,
    parameter int S_ACC_NS = 300,
    parameter int F_OFF_NS = 60,
    parameter int S_OFF_NS = 75
) (
    input wire logic slow,
    input wire logic rom_enable_n,
    input wire logic [12:0] word_index,
    output logic [7:0] byte_out
);
    logic [12:0] held_reg;
    logic [7:0] last_reg = 8'h5A;
    initial byte_out = 8'hA5;
    ////////////////////////////////////////
    // Latch on the falling enable, show the byte once access time has run
    always @(negedge rom_enable_n) begin
        held_reg = word_index;
        byte_out = ~last_reg;
        if (slow) begin
            #(S_ACC_NS);
        end else begin
            #(F_ACC_NS);
        end
        if (!rom_enable_n) begin
            byte_out = held_reg[7:0] ^ {3'h0, held_reg[12:8]};
            last_reg = byte_out;
        end
    end
    // Released lines stop showing the last byte
    always @(posedge rom_enable_n) begin
        if (slow) begin
            #(S_OFF_NS);
        end else begin
            #(F_OFF_NS);
        end
        byte_out = ~last_reg;
    end
endmodule

//--- verification/test_latched_mask_rom_read.sv
`timescale 1ns/10ps
// Reads boundary indices in the fast grade and random indices in both grades
module test_latched_mask_rom_read;
    logic core_clk = 1'b0, resetn = 1'b0, slow_grade = 1'b0, req_valid = 1'b0;
    logic req_ready, rsp_valid, rom_enable_n;
    logic [12:0] req_index = 13'h0000, word_index;
    logic [7:0] rsp_byte, byte_out;
    int errors = 0, checks_done = 0, seed = 32'h239d, cyc = 0;
    logic rom_slow = 1'b0;
    int exp_q[$];
    always #2 core_clk = ~core_clk;
    lmr_host dut_u (.core_clk(core_clk), .resetn(resetn), .slow_grade(slow_grade),
        .req_valid(req_valid), .req_ready(req_ready), .req_index(req_index),
        .rsp_valid(rsp_valid), .rsp_byte(rsp_byte), .rom_enable_n(rom_enable_n),
        .word_index(word_index), .byte_out(byte_out));
    lmr_rom_model rom_u (.slow(rom_slow), .rom_enable_n(rom_enable_n), .word_index(word_index),
        .byte_out(byte_out));
    ////////////////////////////////////////
    // Compare and count
    task check(input logic [12:0] seen, input logic [12:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Print counts and verdict
    task end_of_test;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            end_of_test;
        end
    end
    // One read; inputs scrambled while busy must not disturb it
    task rd(input int idx, input bit g);
        int n;
        exp_q.push_back((idx % 256) ^ (idx / 256));
        req_valid = 1'b1;
        req_index = idx[12:0];
        slow_grade = g;
        rom_slow = g;
        while (req_ready !== 1'b1) @(posedge core_clk) #1;
        @(posedge core_clk) #1;
        req_index = 13'($random(seed));
        slow_grade = 1'($random(seed));
        req_valid = idx[0];
        n = 0;
        while (rsp_valid !== 1'b1 && n < 200) begin
            @(posedge core_clk) #1;
            n++;
        end
        check({12'h000, rsp_valid}, 13'h0001);
        check({5'h00, rsp_byte}, 13'(exp_q.pop_front()));
        check(word_index, idx[12:0]);
        $display("read %h grade %0d done", idx, g);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(posedge core_clk);
        #1 check({10'h000, rom_enable_n, req_ready, rsp_valid}, 13'h0006);
        resetn = 1'b1;
        for (int i = 0; i < 16; i++) begin
            rd(i == 0 ? 0 : (i == 1 ? 8191 : ($random(seed) & 8191)), i[1]);
        end
        end_of_test;
    end
endmodule
